// ==== logic/sar_pkg.sv ====
// Encodings and field positions for the packed arithmetic right shifter
`default_nettype none
package sar_pkg;
  // Instruction field positions
  localparam int MAJOR_HI = 31;
  localparam int MAJOR_LO = 26;
  localparam int AMT_HI = 25;
  localparam int AMT_LO = 21;
  localparam int BYTE_IMM_HI = 23;
  localparam int SUBOP_HI = 10;
  localparam int SUBOP_LO = 6;
  localparam int FUNC_HI = 5;
  localparam int FUNC_LO = 0;
  // Opcode values
  localparam logic [5:0] EXTENSION_MAJOR_OPCODE = 6'h1F;
  localparam logic [5:0] SHIFT_GROUP_FUNCTION = 6'h13;
  // Sub-operation values
  localparam logic [4:0] SUB_BYTE_IMM = 5'h04;
  localparam logic [4:0] SUB_BYTE_IMM_ROUND = 5'h05;
  localparam logic [4:0] SUB_BYTE_VAR = 5'h06;
  localparam logic [4:0] SUB_BYTE_VAR_ROUND = 5'h07;
  localparam logic [4:0] SUB_HALF_VAR = 5'h0B;
  localparam logic [4:0] SUB_HALF_VAR_ROUND = 5'h0F;
  localparam logic [4:0] SUB_WORD_IMM_ROUND = 5'h15;
  // Lane geometry
  localparam int BYTE_LANES = 4;
  localparam int HALF_LANES = 2;
  // Reset values
  localparam logic [31:0] RESULT_RESET = 32'h0000_0000;
  localparam logic FLAG_RESET = 1'b0;
endpackage : sar_pkg
`default_nettype wire

// ==== logic/sar_lane.sv ====
// One lane of arithmetic right shift with optional rounding
`timescale 1ns/100ps
`default_nettype none
module sar_lane #(
  parameter int W = 8,
  parameter int SW = 3
) (
  // Operand
  input wire logic [W-1:0] value,
  input wire logic [SW-1:0] amount,
  input wire logic round_en,
  // Result
  output logic [W-1:0] result
);
  logic signed [W:0] ext;
  logic signed [W:0] shifted;
  logic [W:0] rounded;

  // Value with a guard bit appended below, shifted with sign fill
  assign ext = {value, 1'b0};
  assign shifted = ext >>> amount;
  // Increment at the top discarded bit; a zero amount leaves value intact
  assign rounded = shifted + (W+1)'(1);
  // Keep the upper bits; plain form drops the guard bit
  assign result = round_en ? rounded[W:1] : shifted[W:1];
endmodule : sar_lane
`default_nettype wire

// ==== logic/simd_arith_right_shifter.sv ====
// Packed arithmetic right shifter for bytes, halfwords and a word
`timescale 1ns/100ps
`default_nettype none
// Function
// - Immediate byte form shifts four bytes by three-bit amount, sign filled.
// - Rounding byte forms add one at top discarded bit, per byte.
// - Byte rounding uses nine-bit value, increment, keep upper eight; zero amount unchanged.
// - Word rounding form shifts word by five-bit immediate with sign fill and rounding.
// - Word rounding uses 33-bit intermediate, returns bits 32..1; zero passes unchanged.
// - Variable halfword forms shift both halves by low four amount bits.
// - Rounding halfword variant adds one at top discarded bit per half.
// - Variable byte forms take amount from three lowest register bits only.
// - Word rounding decoded by major, function and sub-operation codes, amount 25..21.
// - Sub-operations for plain and rounding variable byte shifts, amount register.
// - Sub-operations for plain and rounding variable halfword shifts.
// - No exception depends on operand values.
// - Reserved or extension-disabled exception replaces execution when core requires.
// - Halfword rounding uses 17-bit intermediate, returns bits 16..1.
module simd_arith_right_shifter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Issue from the pipeline
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] source_operand,
  input wire logic [31:0] amount_register,
  // Core state
  input wire logic ext_implemented,
  input wire logic ext_enabled,
  // Write-back
  output logic result_valid,
  output logic [31:0] result,
  // Exceptions
  output logic reserved_instr_exc,
  output logic ext_disabled_exc
);
  // Decoded fields and form strobes
  logic [5:0] major_field;
  logic [5:0] func_field;
  logic [4:0] subop_field;
  logic group_hit;
  logic byte_arith_shift_imm;
  logic byte_arith_shift_imm_round;
  logic byte_arith_shift_var;
  logic byte_arith_shift_var_round;
  logic half_arith_shift_var;
  logic half_arith_shift_var_round;
  logic word_arith_shift_imm_round;

  // Operation classes, rounding selects and amounts
  logic is_byte;
  logic is_half;
  logic is_word;
  logic op_hit;
  logic byte_round;
  logic half_round;
  logic [2:0] byte_amount;
  logic [3:0] half_amount;
  logic [4:0] word_amount;

  // Lane results
  logic [31:0] byte_result;
  logic [31:0] half_result;
  logic [31:0] word_result;
  logic [31:0] comb_result;

  // Issue outcome and write-back
  logic take_reserved;
  logic take_disabled;
  logic execute;
  logic result_valid_next;
  logic [31:0] result_next;
  logic byte_imm_form;
  logic byte_var_form;
  logic [2:0] byte_imm_amount;
  logic [2:0] byte_var_amount;
  logic [31:0] word_pick;
  logic [31:0] half_pick;
  logic [31:0] byte_pick;
  logic issue_hit;
  logic ext_ready;

  // Instruction field extraction
  assign major_field = instr[sar_pkg::MAJOR_HI:sar_pkg::MAJOR_LO];
  assign func_field = instr[sar_pkg::FUNC_HI:sar_pkg::FUNC_LO];
  assign subop_field = instr[sar_pkg::SUBOP_HI:sar_pkg::SUBOP_LO];
  // Shift group match on major opcode and function code
  assign group_hit = (major_field == sar_pkg::EXTENSION_MAJOR_OPCODE) &&
                     (func_field == sar_pkg::SHIFT_GROUP_FUNCTION);

  assign word_arith_shift_imm_round = group_hit &&
                                      (subop_field == sar_pkg::SUB_WORD_IMM_ROUND);
  assign byte_arith_shift_var = group_hit && (subop_field == sar_pkg::SUB_BYTE_VAR);
  assign byte_arith_shift_var_round = group_hit &&
                                      (subop_field == sar_pkg::SUB_BYTE_VAR_ROUND);
  assign half_arith_shift_var = group_hit && (subop_field == sar_pkg::SUB_HALF_VAR);
  assign half_arith_shift_var_round = group_hit &&
                                      (subop_field == sar_pkg::SUB_HALF_VAR_ROUND);
  // Immediate byte decode
  assign byte_arith_shift_imm = group_hit && (subop_field == sar_pkg::SUB_BYTE_IMM);
  assign byte_arith_shift_imm_round = group_hit &&
                                      (subop_field == sar_pkg::SUB_BYTE_IMM_ROUND);

  // Operation classes and rounding selects
  assign byte_imm_form = byte_arith_shift_imm | byte_arith_shift_imm_round;
  assign byte_var_form = byte_arith_shift_var | byte_arith_shift_var_round;
  assign is_byte = byte_imm_form | byte_var_form;
  assign is_half = half_arith_shift_var | half_arith_shift_var_round;
  assign is_word = word_arith_shift_imm_round;
  assign op_hit = is_byte | is_half | is_word;
  assign byte_round = byte_arith_shift_imm_round | byte_arith_shift_var_round;
  assign half_round = half_arith_shift_var_round;

  assign byte_imm_amount = instr[sar_pkg::BYTE_IMM_HI:sar_pkg::AMT_LO];
  // variable byte amount, upper register bits ignored
  assign byte_var_amount = amount_register[2:0];
  assign byte_amount = byte_var_form ? byte_var_amount : byte_imm_amount;
  // halfword amount from low four bits
  assign half_amount = amount_register[3:0];
  assign word_amount = instr[sar_pkg::AMT_HI:sar_pkg::AMT_LO];

  genvar gb;
  generate
    for (gb = 0; gb < sar_pkg::BYTE_LANES; gb++) begin : g_byte
      sar_lane #(.W(8), .SW(3)) u_lane (
        .value(source_operand[gb*8 +: 8]),
        .amount(byte_amount),
        .round_en(byte_round),
        .result(byte_result[gb*8 +: 8])
      );
    end
  endgenerate

  genvar gh;
  generate
    for (gh = 0; gh < sar_pkg::HALF_LANES; gh++) begin : g_half
      sar_lane #(.W(16), .SW(4)) u_lane (
        .value(source_operand[gh*16 +: 16]),
        .amount(half_amount),
        .round_en(half_round),
        .result(half_result[gh*16 +: 16])
      );
    end
  endgenerate

  sar_lane #(.W(32), .SW(5)) u_word (
    .value(source_operand),
    .amount(word_amount),
    .round_en(1'b1),
    .result(word_result)
  );

  // same-stage result selection; the decoded forms never overlap
  assign word_pick = is_word ? word_result : sar_pkg::RESULT_RESET;
  assign half_pick = is_half ? half_result : sar_pkg::RESULT_RESET;
  assign byte_pick = is_byte ? byte_result : sar_pkg::RESULT_RESET;
  assign comb_result = word_pick | half_pick | byte_pick;

  // Issue of a decoded shift form, and an extension ready to run it
  assign issue_hit = issue_valid & op_hit;
  assign ext_ready = ext_implemented & ext_enabled;
  // exceptions depend on the decoded issue and core state only
  assign take_reserved = issue_hit & ~ext_implemented;
  assign take_disabled = issue_hit & ext_implemented & ~ext_enabled;
  assign execute = issue_hit & ext_ready;

  // Register next values; a refused or absent issue keeps the old result
  assign result_valid_next = execute;
  assign result_next = execute ? comb_result : result;

  // Write-back strobe, one cycle per executed shift
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result_valid <= sar_pkg::FLAG_RESET;
    end else begin
      result_valid <= result_valid_next;
    end
  end

  // Result register; holds until the next executed shift
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= sar_pkg::RESULT_RESET;
    end else begin
      result <= result_next;
    end
  end

  // Reserved-instruction pulse, one cycle per issue refused with the extension not implemented
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reserved_instr_exc <= sar_pkg::FLAG_RESET;
    end else begin
      reserved_instr_exc <= take_reserved;
    end
  end

  // Extension-disabled pulse, one cycle per issue refused with the extension implemented but disabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_disabled_exc <= sar_pkg::FLAG_RESET;
    end else begin
      ext_disabled_exc <= take_disabled;
    end
  end
endmodule : simd_arith_right_shifter
`default_nettype wire

// ==== verif/sar_properties.sv ====
// Port assertions for the packed arithmetic right shifter
`timescale 1ns/100ps
`default_nettype none
module sar_properties (
  // Watched ports
  input wire logic clk,
  input wire logic rst_b,
  input wire logic issue_valid,
  input wire logic [31:0] instr,
  input wire logic [31:0] source_operand,
  input wire logic [31:0] amount_register,
  input wire logic ext_implemented,
  input wire logic ext_enabled,
  input wire logic result_valid,
  input wire logic [31:0] result,
  input wire logic reserved_instr_exc,
  input wire logic ext_disabled_exc
);
  // Decode of the seven shift forms
  wire logic [4:0] sub = instr[10:6];
  wire logic hit = issue_valid && instr[31:26] == 6'h1F && instr[5:0] == 6'h13
    && sub inside {5'h04, 5'h05, 5'h06, 5'h07, 5'h0B, 5'h0F, 5'h15};
  wire logic go = hit && ext_implemented && ext_enabled;
  wire logic exc = reserved_instr_exc || ext_disabled_exc;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  exec_latency_a: assert property (go |=> result_valid && !exc)
    else $error("executed shift not written back");
  idle_quiet_a: assert property (!hit |=> !result_valid && !exc)
    else $error("output without a shift issue");
  reserved_first_a: assert property (hit && !ext_implemented |=> reserved_instr_exc
    && !ext_disabled_exc && !result_valid) else $error("reserved exception missing");
  disabled_exc_a: assert property (hit && ext_implemented && !ext_enabled
    |=> ext_disabled_exc && !reserved_instr_exc && !result_valid) else $error("disabled missing");
  exc_hold_a: assert property (exc |-> $stable(result))
    else $error("result changed on exception");
  word_zero_a: assert property (go && sub == 5'h15 && instr[25:21] == 5'h00
    |=> result == $past(source_operand)) else $error("word zero shift altered");
  byte_mask_a: assert property (go && sub == 5'h06 && amount_register[2:0] == 3'h0
    |=> result == $past(source_operand)) else $error("byte amount mask wrong");
  half_mask_a: assert property (go && sub == 5'h0B && amount_register[3:0] == 4'h0
    |=> result == $past(source_operand)) else $error("half amount mask wrong");
endmodule : sar_properties
bind simd_arith_right_shifter sar_properties i_sar_properties (.clk, .rst_b, .issue_valid,
  .instr, .source_operand, .amount_register, .ext_implemented, .ext_enabled, .result_valid,
  .result, .reserved_instr_exc, .ext_disabled_exc);
`default_nettype wire

// ==== verif/issue_source.sv ====
// Pipeline model presenting shift instructions and operands
`timescale 1ns/100ps
`default_nettype none
module issue_source (
  // Clock
  input wire logic clk,
  // Issue group
  output logic issue_valid = 1'b0,
  output logic [31:0] instr = 32'h0,
  output logic [31:0] source_operand = 32'h0,
  output logic [31:0] amount_register = 32'h0
);
  // Present one instruction after a falling edge
  task automatic send(input logic [4:0] sub, input logic [4:0] a5, input logic [31:0] v,
    input logic [31:0] rs);
    @(negedge clk);
    issue_valid <= 1'b1;
    instr <= {6'h1F, a5, 10'h2A5, sub, 6'h13};
    source_operand <= v;
    amount_register <= rs;
  endtask : send
  // Drop the issue and scramble the stale instruction and source operand; amount register kept
  task automatic idle();
    @(negedge clk);
    issue_valid <= 1'b0;
    instr <= ~instr;
    source_operand <= ~source_operand;
  endtask : idle
endmodule : issue_source
`default_nettype wire

// ==== verif/tb_simd_arith_right_shifter.sv ====
// Self-checking bench for the packed arithmetic right shifter
`timescale 1ns/100ps
`default_nettype none
module tb_simd_arith_right_shifter;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ext_implemented = 1'b1;
  logic ext_enabled = 1'b1;
  logic issue_valid, result_valid, reserved_instr_exc, ext_disabled_exc;
  logic [31:0] instr, source_operand, amount_register, result, r;
  logic [31:0] seed = 32'h0000_7C83;
  logic [31:0] last_res = 32'h0000_0000;
  logic [34:0] exp_q[$];
  logic [34:0] note;
  logic [4:0] subs[7] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h0B, 5'h0F, 5'h15};
  int bad_count = 0;
  int total_checks = 0;
  int n;
  always #5 clk = ~clk;
  issue_source i_issue_source (.clk, .issue_valid, .instr, .source_operand, .amount_register);
  simd_arith_right_shifter i_simd_arith_right_shifter (.clk, .rst_b, .issue_valid, .instr,
    .source_operand, .amount_register, .ext_implemented, .ext_enabled, .result_valid,
    .result, .reserved_instr_exc, .ext_disabled_exc);
  // Xorshift source of operands
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // One lane: sign fill, optional round at the top discarded bit
  function automatic logic [31:0] lane(logic [31:0] v, int w, int s, bit rd);
    logic signed [31:0] x;
    longint t;
    x = $signed(v << (32 - w)) >>> (32 - w);
    t = ((longint'(x) <<< 1) >>> s) + (rd ? 1 : 0);
    t = t >>> 1;
    return 32'(t) & (32'hFFFF_FFFF >> (32 - w));
  endfunction : lane
  // Expected packed result of one form
  function automatic logic [31:0] want(logic [4:0] sub, logic [4:0] a5, logic [31:0] v,
    logic [31:0] rs);
    int w, s;
    logic [31:0] o = 32'h0;
    w = sub == 5'h15 ? 32 : sub >= 5'h0B ? 16 : 8;
    s = sub == 5'h15 ? a5 : sub >= 5'h0B ? rs[3:0] : sub >= 5'h06 ? rs[2:0] : a5[2:0];
    for (int k = 0; k < 32; k += w) o |= lane(v >> k, w, s, sub[0] && sub != 5'h0B) << k;
    return o;
  endfunction : want
  // Issue one shift and note what must come back
  task automatic issue(logic [4:0] sub, logic [4:0] a5, logic [31:0] v, logic [31:0] rs);
    i_issue_source.send(sub, a5, v, rs);
    if (!ext_implemented) exp_q.push_back({3'b010, last_res});
    else if (!ext_enabled) exp_q.push_back({3'b001, last_res});
    else begin
      last_res = want(sub, a5, v, rs);
      exp_q.push_back({3'b100, last_res});
    end
  endtask : issue
  // Compare each write-back or exception with the oldest note
  always @(negedge clk) begin
    if (result_valid || reserved_instr_exc || ext_disabled_exc) begin
      total_checks++;
      note = exp_q.size() ? exp_q[0] : 35'h0;
      if (exp_q.size() == 0 || exp_q.pop_front() !== {result_valid,
          reserved_instr_exc, ext_disabled_exc, result}) begin
        bad_count++;
        $display("[ERR] result exp %h got %h", note, {result_valid, reserved_instr_exc,
          ext_disabled_exc, result});
      end
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (2000) @(posedge clk);
    bad_count++;
    $display("[ERR] watchdog exp done got hang");
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    foreach (subs[i]) begin
      n = subs[i] == 5'h15 ? 32 : subs[i] >= 5'h0B ? 16 : 8;
      for (int s = 0; s < n; s++) begin
        r = rnd();
        if (subs[i] inside {5'h04, 5'h05, 5'h15}) issue(subs[i], 5'(s), rnd(), r);
        else issue(subs[i], r[4:0], rnd(), (r & ~32'(n - 1)) | 32'(s));
      end
    end
    issue(5'h15, 5'h01, 32'h7FFF_FFFF, rnd());
    issue(5'h05, 5'h01, 32'h7F80_7F80, rnd());
    issue(5'h0F, 5'h00, 32'h7FFF_8001, 32'hFFFF_FFF1);
    i_issue_source.send(5'h03, 5'h01, rnd(), rnd());
    i_issue_source.idle();
    $display("sweep test done");
    ext_enabled = 1'b0;
    issue(5'h07, 5'h02, rnd(), rnd());
    i_issue_source.idle();
    ext_implemented = 1'b0;
    issue(5'h0B, 5'h02, rnd(), rnd());
    i_issue_source.idle();
    ext_implemented = 1'b1;
    ext_enabled = 1'b1;
    repeat (3) i_issue_source.idle();
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("[ERR] pending exp 0 got %0d", exp_q.size());
    end
    $display("exception test done");
    report_and_stop();
  end
endmodule : tb_simd_arith_right_shifter
`default_nettype wire
